// [logic/filter_regs_pkg.sv]
// Offsets, field layouts, reset values and constants of the queue count and hash filter registers
package filter_regs_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [7:0] OFS_RX_FRAME_COUNT_THRESHOLD = 8'h9C;
	localparam logic [7:0] OFS_TX_NEXT_SPACE_REQUEST = 8'h9E;
	localparam logic [7:0] OFS_MULTICAST_HASH_WORD0 = 8'hA0;
	localparam logic [7:0] OFS_MULTICAST_HASH_WORD1 = 8'hA2;
	localparam logic [7:0] OFS_MULTICAST_HASH_WORD2 = 8'hA4;
	localparam logic [7:0] OFS_MULTICAST_HASH_WORD3 = 8'hA6;
	localparam logic [7:0] OFS_RX_FLOW_LOW_WATERMARK = 8'hB0;

	////////////////////////////////////////////////////////////////////////
	// Field layouts
	localparam int REG_WIDTH = 16;
	localparam int BYTE_WIDTH = 8;
	localparam int FRAME_COUNT_WIDTH = 8;
	localparam int FRAME_COUNT_LSB = 8;
	localparam int THRESHOLD_LSB = 0;
	localparam int WATERMARK_WIDTH = 12;
	localparam int HASH_WORDS = 4;
	localparam int HASH_INDEX_WIDTH = 6;
	localparam int HASH_BIT_SEL_WIDTH = 4;
	localparam int HASH_WORD_SEL_WIDTH = 2;
	localparam int DA_WIDTH = 48;
	localparam int CRC_WIDTH = 32;
	localparam int GROUP_BIT = 0;

	////////////////////////////////////////////////////////////////////////
	// Reset values and encodings
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [11:0] LOW_WATERMARK_RESET = 12'h500;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
	localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
	localparam logic [2:0] HASH_PERFECT_MODE = 3'h5;

endpackage

// [logic/frame_count_tracker.sv]
// Receive queue frame counter, threshold compare and receive flag
`timescale 1ns/10ps
module frame_count_tracker
	import filter_regs_pkg::*;
#(
	parameter int COUNT_WIDTH = FRAME_COUNT_WIDTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Queue events
	input wire logic frameArrived,
	input wire logic frameReleased,
	// Control
	input wire logic thresholdEnable,
	input wire logic [COUNT_WIDTH-1:0] threshold,
	input wire logic flagClear,
	// State
	output logic [COUNT_WIDTH-1:0] framesInQueue,
	output logic [COUNT_WIDTH-1:0] countSnapshot,
	output logic rxFrameFlag
);

	logic [COUNT_WIDTH-1:0] count_q, count_d;
	logic [COUNT_WIDTH-1:0] snap_q, snap_d;
	logic flag_q, flag_d;
	logic setEvent;

	always_comb begin
		count_d = count_q;
		// Saturate instead of wrapping; a wrapped count would fake an empty queue
		if (frameArrived && !frameReleased && count_q != '1) begin
			count_d = count_q + 1'b1;
		end else if (frameReleased && !frameArrived && count_q != '0) begin
			count_d = count_q - 1'b1;
		end
		setEvent = frameArrived && (!thresholdEnable || count_d > threshold); // R3 R12
		flag_d = setEvent || (flag_q && !flagClear); // R12 R2
		snap_d = setEvent ? count_d : snap_q; // R1
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count_q <= '0;
			snap_q <= '0;
			flag_q <= 1'b0;
		end else begin
			count_q <= count_d;
			snap_q <= snap_d;
			flag_q <= flag_d;
		end
	end

	assign framesInQueue = count_q;
	assign countSnapshot = snap_q;
	assign rxFrameFlag = flag_q;

endmodule

// [logic/hash_index_crc.sv]
// CRC over a destination address, giving the six-bit hash index
`timescale 1ns/10ps
module hash_index_crc
	import filter_regs_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Address in, first wire octet in the low byte
	input wire logic daValid,
	input wire logic [DA_WIDTH-1:0] destAddr,
	// Index out
	output logic indexValid,
	output logic [HASH_INDEX_WIDTH-1:0] hashIndex,
	output logic isGroup
);

	logic valid_q, valid_d;
	logic [HASH_INDEX_WIDTH-1:0] index_q, index_d;
	logic group_q, group_d;
	logic [CRC_WIDTH-1:0] crc;

	// Bits go in least significant first, as they leave on the wire
	function automatic logic [CRC_WIDTH-1:0] crcOf(input logic [DA_WIDTH-1:0] da);
		logic [CRC_WIDTH-1:0] c;
		c = CRC_INIT;
		for (int i = 0; i < DA_WIDTH; i++) begin
			c = {c[CRC_WIDTH-2:0], 1'b0} ^ ((c[CRC_WIDTH-1] ^ da[i]) ? CRC_POLY : '0);
		end
		return c;
	endfunction

	assign crc = crcOf(destAddr);

	always_comb begin
		valid_d = daValid;
		index_d = index_q;
		group_d = group_q;
		if (daValid) begin
			index_d = crc[CRC_WIDTH-1 -: HASH_INDEX_WIDTH]; // R6
			group_d = destAddr[GROUP_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			valid_q <= 1'b0;
			index_q <= '0;
			group_q <= 1'b0;
		end else begin
			valid_q <= valid_d;
			index_q <= index_d;
			group_q <= group_d;
		end
	end

	assign indexValid = valid_q;
	assign hashIndex = index_q;
	assign isGroup = group_q;

endmodule

// [logic/queue_count_hash_filter_regs.sv]
// Queue frame count, transmit space request, multicast hash filter and low watermark registers
`timescale 1ns/10ps

// How it works
// R1: The upper byte of the frame count register shows the frames waiting at the last arrival that met the receive flag set condition.
// R2: The host clears the receive flag by writing one and reads the frame count before header data.
// R3: With threshold enabled, the receive flag rises once the waiting count exceeds the threshold.
// R4: The host writes a 16-bit transmit space request counted in double words.
// R5: With the space monitor enabled, the space flag rises once free space reaches the request.
// R6: A CRC over the 48-bit destination address gives a six-bit hash index from its top bits.
// R7: The top two index bits pick one of four hash words, the low four bits pick the bit.
// R8: The hash lookup applies only in hash-perfect filter mode.
// R9: A multicast frame whose hash bit is one is accepted, otherwise dropped.
// R10: Receive-all or receive-multicast accepts every multicast frame without the table.
// R11: A 12-bit low watermark in double words resets to 0x500, upper four bits reserved.
// R12: The receive flag is edge set when a frame is ready and cleared by writing one.
// R13: The space flag shows that the requested transmit space has become available.
// R14: Flow control is released once free receive space rises above the low watermark.
module queue_count_hash_filter_regs
	import filter_regs_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register access
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regAddr,
	input wire logic [1:0] regByteEn,
	input wire logic [REG_WIDTH-1:0] regWrData,
	output logic [REG_WIDTH-1:0] regRdData,
	// Control bits held in other registers
	input wire logic rxThresholdEnable,
	input wire logic txSpaceMonitorEnable,
	input wire logic [2:0] filterMode,
	input wire logic acceptAllFrames,
	input wire logic acceptAllMulticast,
	input wire logic rxFlagClear,
	input wire logic txSpaceFlagClear,
	// Receive queue
	input wire logic frameArrived,
	input wire logic frameReleased,
	input wire logic [WATERMARK_WIDTH-1:0] rxFreeSpace,
	output logic rxFrameFlag,
	output logic flowRelease,
	// Transmit queue
	input wire logic [REG_WIDTH-1:0] txFreeSpace,
	output logic txSpaceFlag,
	// Address filter
	input wire logic daValid,
	input wire logic [DA_WIDTH-1:0] destAddr,
	output logic filterDone,
	output logic frameAccept
);

	////////////////////////////////////////////////////////////////////////
	// State

	logic [FRAME_COUNT_WIDTH-1:0] threshold_q, threshold_d;
	logic [REG_WIDTH-1:0] txSpaceRequested_q, txSpaceRequested_d;
	logic [REG_WIDTH-1:0] hashWord_q [HASH_WORDS];
	logic [REG_WIDTH-1:0] hashWord_d [HASH_WORDS];
	logic [WATERMARK_WIDTH-1:0] lowWatermark_q, lowWatermark_d;
	logic [REG_WIDTH-1:0] rdData_q, rdData_d;
	logic txFlag_q, txFlag_d;
	logic txAvail_q, txAvail_d;
	logic flow_q, flow_d;
	logic done_q, done_d;
	logic accept_q, accept_d;

	logic [FRAME_COUNT_WIDTH-1:0] framesInQueue;
	logic [FRAME_COUNT_WIDTH-1:0] countSnapshot;
	logic indexValid;
	logic [HASH_INDEX_WIDTH-1:0] hashIndex;
	logic isGroup;
	logic hashBit;
	logic hashMode;
	logic txAvail;
	logic [REG_WIDTH-1:0] wmMerged;

	// Byte lane merge; a lane not enabled keeps its old value
	function automatic logic [REG_WIDTH-1:0] mergeLanes(
		input logic [REG_WIDTH-1:0] oldVal,
		input logic [REG_WIDTH-1:0] newVal,
		input logic [1:0] be
	);
		logic [REG_WIDTH-1:0] r;
		r = oldVal;
		if (be[0]) begin
			r[BYTE_WIDTH-1:0] = newVal[BYTE_WIDTH-1:0];
		end
		if (be[1]) begin
			r[REG_WIDTH-1:BYTE_WIDTH] = newVal[REG_WIDTH-1:BYTE_WIDTH];
		end
		return r;
	endfunction

	// Watermark merged as a full word; reserved bits stay zero
	assign wmMerged = mergeLanes({{(REG_WIDTH-WATERMARK_WIDTH){1'b0}}, lowWatermark_q},
		regWrData, regByteEn);

	////////////////////////////////////////////////////////////////////////
	// Submodules

	frame_count_tracker #(
		.COUNT_WIDTH(FRAME_COUNT_WIDTH)
	) u_frame_count (
		.clk(clk),
		.rst_n(rst_n),
		.frameArrived(frameArrived),
		.frameReleased(frameReleased),
		.thresholdEnable(rxThresholdEnable),
		.threshold(threshold_q),
		.flagClear(rxFlagClear),
		.framesInQueue(framesInQueue),
		.countSnapshot(countSnapshot),
		.rxFrameFlag(rxFrameFlag)
	);

	hash_index_crc u_hash_crc (
		.clk(clk),
		.rst_n(rst_n),
		.daValid(daValid),
		.destAddr(destAddr),
		.indexValid(indexValid),
		.hashIndex(hashIndex),
		.isGroup(isGroup)
	);

	////////////////////////////////////////////////////////////////////////
	// Register writes and reads

	always_comb begin
		threshold_d = threshold_q;
		txSpaceRequested_d = txSpaceRequested_q;
		lowWatermark_d = lowWatermark_q;
		for (int w = 0; w < HASH_WORDS; w++) begin
			hashWord_d[w] = hashWord_q[w];
		end
		if (regWrite) begin
			case (regAddr)
				OFS_RX_FRAME_COUNT_THRESHOLD: begin
					// Upper byte is the read-only frame count
					if (regByteEn[0]) begin
						threshold_d = regWrData[THRESHOLD_LSB +: FRAME_COUNT_WIDTH]; // R3
					end
				end
				OFS_TX_NEXT_SPACE_REQUEST: begin
					txSpaceRequested_d = mergeLanes(txSpaceRequested_q, regWrData, regByteEn); // R4
				end
				OFS_MULTICAST_HASH_WORD0: begin
					hashWord_d[0] = mergeLanes(hashWord_q[0], regWrData, regByteEn);
				end
				OFS_MULTICAST_HASH_WORD1: begin
					hashWord_d[1] = mergeLanes(hashWord_q[1], regWrData, regByteEn);
				end
				OFS_MULTICAST_HASH_WORD2: begin
					hashWord_d[2] = mergeLanes(hashWord_q[2], regWrData, regByteEn);
				end
				OFS_MULTICAST_HASH_WORD3: begin
					hashWord_d[3] = mergeLanes(hashWord_q[3], regWrData, regByteEn);
				end
				OFS_RX_FLOW_LOW_WATERMARK: begin
					lowWatermark_d = wmMerged[WATERMARK_WIDTH-1:0]; // R11
				end
				default: begin
				end
			endcase
		end
		rdData_d = rdData_q;
		if (regRead) begin
			case (regAddr)
				OFS_RX_FRAME_COUNT_THRESHOLD: begin
					rdData_d = {countSnapshot, threshold_q}; // R1
				end
				OFS_TX_NEXT_SPACE_REQUEST: begin
					rdData_d = txSpaceRequested_q;
				end
				OFS_MULTICAST_HASH_WORD0: begin
					rdData_d = hashWord_q[0];
				end
				OFS_MULTICAST_HASH_WORD1: begin
					rdData_d = hashWord_q[1];
				end
				OFS_MULTICAST_HASH_WORD2: begin
					rdData_d = hashWord_q[2];
				end
				OFS_MULTICAST_HASH_WORD3: begin
					rdData_d = hashWord_q[3];
				end
				OFS_RX_FLOW_LOW_WATERMARK: begin
					rdData_d = {{(REG_WIDTH-WATERMARK_WIDTH){1'b0}}, lowWatermark_q}; // R11
				end
				default: begin
					rdData_d = REG_RESET;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			threshold_q <= COUNT_RESET;
			txSpaceRequested_q <= REG_RESET;
			lowWatermark_q <= LOW_WATERMARK_RESET; // R11
			rdData_q <= REG_RESET;
			for (int w = 0; w < HASH_WORDS; w++) begin
				hashWord_q[w] <= REG_RESET;
			end
		end else begin
			threshold_q <= threshold_d;
			txSpaceRequested_q <= txSpaceRequested_d;
			lowWatermark_q <= lowWatermark_d;
			rdData_q <= rdData_d;
			for (int w = 0; w < HASH_WORDS; w++) begin
				hashWord_q[w] <= hashWord_d[w];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmit space monitor, filter decision and flow release

	assign txAvail = txSpaceMonitorEnable && (txFreeSpace >= txSpaceRequested_q); // R5
	assign hashMode = (filterMode == HASH_PERFECT_MODE); // R8
	assign hashBit = hashWord_q[hashIndex[HASH_INDEX_WIDTH-1 -: HASH_WORD_SEL_WIDTH]]
		[hashIndex[HASH_BIT_SEL_WIDTH-1:0]]; // R7

	always_comb begin
		txAvail_d = txAvail;
		// Edge set so a lasting surplus does not refire after a clear
		txFlag_d = (txAvail && !txAvail_q) || (txFlag_q && !txSpaceFlagClear); // R5 R13
		flow_d = rxFreeSpace > lowWatermark_q; // R14
		done_d = indexValid;
		accept_d = accept_q;
		if (indexValid) begin
			if (!isGroup) begin
				accept_d = 1'b1;
			end else if (acceptAllFrames || acceptAllMulticast) begin
				accept_d = 1'b1; // R10
			end else if (hashMode) begin
				accept_d = hashBit; // R9
			end else begin
				accept_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			txAvail_q <= 1'b0;
			txFlag_q <= 1'b0;
			flow_q <= 1'b0;
			done_q <= 1'b0;
			accept_q <= 1'b0;
		end else begin
			txAvail_q <= txAvail_d;
			txFlag_q <= txFlag_d;
			flow_q <= flow_d;
			done_q <= done_d;
			accept_q <= accept_d;
		end
	end

	assign regRdData = rdData_q;
	assign txSpaceFlag = txFlag_q;
	assign flowRelease = flow_q;
	assign filterDone = done_q;
	assign frameAccept = accept_q;

	////////////////////////////////////////////////////////////////////////
	// Checks

	a_count_snapshot: assert property (@(posedge clk) disable iff (!rst_n) // R1
		$rose(rxFrameFlag) |-> countSnapshot == framesInQueue)
		else $error("frame count not caught when receive flag rose");

	a_read_count: assert property (@(posedge clk) disable iff (!rst_n) // R1
		regRead && regAddr == OFS_RX_FRAME_COUNT_THRESHOLD
		|=> regRdData[FRAME_COUNT_LSB +: FRAME_COUNT_WIDTH] == $past(countSnapshot))
		else $error("frame count read mismatch");

	a_rx_flag_arrival: assert property (@(posedge clk) disable iff (!rst_n) // R12
		frameArrived && !rxThresholdEnable |=> rxFrameFlag ##1 (rxFrameFlag || $past(rxFlagClear)))
		else $error("receive flag not set by frame arrival");

	a_rx_threshold_hold: assert property (@(posedge clk) disable iff (!rst_n) // R3
		rxThresholdEnable && !rxFrameFlag && !rxFlagClear && frameReleased
		&& framesInQueue <= threshold_q |=> !rxFrameFlag)
		else $error("receive flag rose below threshold");

	a_tx_space_cause: assert property (@(posedge clk) disable iff (!rst_n) // R5
		$rose(txSpaceFlag) |-> $past(txSpaceMonitorEnable && txFreeSpace >= txSpaceRequested_q))
		else $error("space flag rose without space");

	a_tx_flag_sticky: assert property (@(posedge clk) disable iff (!rst_n) // R13
		txSpaceFlag && !txSpaceFlagClear |=> txSpaceFlag)
		else $error("space flag dropped without clear");

	a_hash_lookup: assert property (@(posedge clk) disable iff (!rst_n) // R9
		indexValid && isGroup && hashMode && !acceptAllFrames && !acceptAllMulticast
		|=> filterDone && frameAccept == $past(hashWord_q[hashIndex[5:4]][hashIndex[3:0]]))
		else $error("hash lookup decision wrong");

	a_multicast_all: assert property (@(posedge clk) disable iff (!rst_n) // R10
		indexValid && (acceptAllFrames || acceptAllMulticast) |=> frameAccept)
		else $error("multicast not accepted with accept-all");

	a_watermark_write: assert property (@(posedge clk) disable iff (!rst_n) // R11
		regWrite && regAddr == OFS_RX_FLOW_LOW_WATERMARK && regByteEn == 2'h3
		|=> lowWatermark_q == $past(regWrData[WATERMARK_WIDTH-1:0]))
		else $error("low watermark write lost");

	a_flow_release: assert property (@(posedge clk) disable iff (!rst_n) // R14
		rxFreeSpace > lowWatermark_q ##1 1'b1 |-> flowRelease)
		else $error("flow not released above watermark");

endmodule

// [verif/host_model.sv]
// Host side register master for the strobe bus
`timescale 1ns/10ps
module host_model
	import filter_regs_pkg::*;
(
	// Clock
	input wire logic clk,
	// Register bus
	output logic regWrite,
	output logic regRead,
	output logic [7:0] regAddr,
	output logic [1:0] regByteEn,
	output logic [REG_WIDTH-1:0] regWrData,
	input wire logic [REG_WIDTH-1:0] regRdData
);
	initial begin
		regWrite = 1'h0;
		regRead = 1'h0;
		regAddr = 8'h00;
		regByteEn = 2'h0;
		regWrData = 16'h0000;
	end
	// Released lines flip so a stale value never looks valid
	task automatic drop();
		regWrite <= 1'h0;
		regRead <= 1'h0;
		regAddr <= ~regAddr;
		regWrData <= ~regWrData;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] be);
		@(posedge clk);
		regWrite <= 1'h1;
		regAddr <= a;
		regByteEn <= be;
		regWrData <= d;
		@(posedge clk);
		drop();
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk);
		regRead <= 1'h1;
		regAddr <= a;
		@(posedge clk);
		drop();
		@(posedge clk);
		#1;
		d = regRdData;
	endtask
endmodule

// [verif/queue_count_hash_filter_regs_bench.sv]
// Self-checking bench for the queue count and hash filter registers
`timescale 1ns/10ps
module queue_count_hash_filter_regs_bench;
	import filter_regs_pkg::*;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic regWrite, regRead;
	logic [7:0] regAddr;
	logic [1:0] regByteEn;
	logic [15:0] regWrData, regRdData;
	logic rxThresholdEnable = 1'h0, txSpaceMonitorEnable = 1'h0;
	logic [2:0] filterMode = 3'h0;
	logic acceptAllFrames = 1'h0, acceptAllMulticast = 1'h0;
	logic rxFlagClear = 1'h0, txSpaceFlagClear = 1'h0;
	logic frameArrived = 1'h0, frameReleased = 1'h0;
	logic [11:0] rxFreeSpace = 12'h000;
	logic [15:0] txFreeSpace = 16'h0000;
	logic daValid = 1'h0;
	logic [47:0] destAddr = 48'h0;
	logic rxFrameFlag, flowRelease, txSpaceFlag, filterDone, frameAccept;
	int failures = 0, checked = 0, cycles = 0;
	int cnt = 0, snap = 0, flag = 0, k;
	logic [15:0] hw [4];
	logic [15:0] d, req;
	logic [47:0] da;
	logic [5:0] idx;
	logic e;
	localparam logic [7:0] ADDRS [8] = '{8'h9C, 8'h9E, 8'hA0, 8'hA2, 8'hA4, 8'hA6, 8'hB0, 8'h98};

	always #10 clk = ~clk;

	host_model host (.clk(clk), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
		.regByteEn(regByteEn), .regWrData(regWrData), .regRdData(regRdData));

	queue_count_hash_filter_regs uut (.clk(clk), .rst_n(rst_n), .regWrite(regWrite),
		.regRead(regRead), .regAddr(regAddr), .regByteEn(regByteEn), .regWrData(regWrData),
		.regRdData(regRdData), .rxThresholdEnable(rxThresholdEnable),
		.txSpaceMonitorEnable(txSpaceMonitorEnable), .filterMode(filterMode),
		.acceptAllFrames(acceptAllFrames), .acceptAllMulticast(acceptAllMulticast),
		.rxFlagClear(rxFlagClear), .txSpaceFlagClear(txSpaceFlagClear),
		.frameArrived(frameArrived), .frameReleased(frameReleased), .rxFreeSpace(rxFreeSpace),
		.rxFrameFlag(rxFrameFlag), .flowRelease(flowRelease), .txFreeSpace(txFreeSpace),
		.txSpaceFlag(txSpaceFlag), .daValid(daValid), .destAddr(destAddr),
		.filterDone(filterDone), .frameAccept(frameAccept));

	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic tally_and_finish();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Bit-serial reference, address sent low bit first
	function automatic logic [5:0] hash_of(input logic [47:0] a);
		logic [31:0] c;
		c = 32'hFFFFFFFF;
		for (int i = 0; i < 48; i++)
			c = {c[30:0], 1'h0} ^ ((c[31] ^ a[i]) ? 32'h04C11DB7 : 32'h0);
		return c[31:26];
	endfunction
	task automatic arrive();
		@(posedge clk) frameArrived <= 1'h1;
		@(posedge clk) frameArrived <= 1'h0;
		cnt++;
		if (!rxThresholdEnable || cnt > 2) begin
			flag = 1;
			snap = cnt;
		end
		tick(1);
		chk(rxFrameFlag, flag);
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			failures++;
			tally_and_finish();
		end
	end

	////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(95));
		repeat (10) @(posedge clk);
		rst_n <= 1'h1;
		for (int i = 0; i < 8; i++) begin
			host.rd(ADDRS[i], d);
			chk(d, (i == 6) ? 16'h0500 : 16'h0000);
		end
		$display("test reset values done");
		for (int i = 0; i < 4; i++) begin
			hw[i] = 16'($urandom);
			host.wr(8'hA0 + 8'(2 * i), hw[i], 2'h3);
		end
		host.wr(8'hA2, 16'hFFFF, 2'h1);
		hw[1][7:0] = 8'hFF;
		for (int i = 0; i < 4; i++) begin
			host.rd(8'hA0 + 8'(2 * i), d);
			chk(d, hw[i]);
		end
		req = 16'($urandom) | 16'h0001;
		host.wr(8'h9E, req, 2'h3);
		host.rd(8'h9E, d);
		chk(d, req);
		host.wr(8'hB0, 16'hF123, 2'h3);
		host.rd(8'hB0, d);
		chk(d, 16'h0123);
		host.wr(8'h9C, 16'hAB02, 2'h3);
		host.rd(8'h9C, d);
		chk(d, 16'h0002);
		$display("test register access done");
		arrive();
		// Count read before any header data
		host.rd(8'h9C, d);
		chk(d, {8'(snap), 8'h02});
		@(posedge clk) rxFlagClear <= 1'h1;
		@(posedge clk) rxFlagClear <= 1'h0;
		flag = 0;
		tick(1);
		chk(rxFrameFlag, flag);
		// Release with threshold on and count below it, flag must stay low
		@(posedge clk) begin
			frameReleased <= 1'h1;
			rxThresholdEnable <= 1'h1;
		end
		@(posedge clk) frameReleased <= 1'h0;
		cnt--;
		repeat (3) arrive();
		host.rd(8'h9C, d);
		chk(d, {8'(snap), 8'h02});
		// Arrival and clear in one cycle: the set wins
		@(posedge clk) begin
			frameArrived <= 1'h1;
			rxFlagClear <= 1'h1;
		end
		@(posedge clk) begin
			frameArrived <= 1'h0;
			rxFlagClear <= 1'h0;
		end
		cnt++;
		snap = cnt;
		tick(1);
		chk(rxFrameFlag, flag);
		host.rd(8'h9C, d);
		chk(d, {8'(snap), 8'h02});
		$display("test receive flag done");
		@(posedge clk);
		txSpaceMonitorEnable <= 1'h1;
		txFreeSpace <= req - 16'h0001;
		tick(3);
		chk(txSpaceFlag, 16'h0);
		@(posedge clk) txFreeSpace <= req;
		tick(2);
		chk(txSpaceFlag, 16'h1);
		@(posedge clk) txSpaceFlagClear <= 1'h1;
		@(posedge clk) txSpaceFlagClear <= 1'h0;
		tick(3);
		chk(txSpaceFlag, 16'h0);
		$display("test transmit space done");
		@(posedge clk) rxFreeSpace <= 12'h123;
		tick(2);
		chk(flowRelease, 16'h0);
		@(posedge clk) rxFreeSpace <= 12'h124;
		tick(2);
		chk(flowRelease, 16'h1);
		$display("test flow release done");
		for (int i = 0; i < 40; i++) begin
			k = i % 5;
			da = {16'($urandom), 32'($urandom)};
			da[0] = (k != 1);
			@(posedge clk);
			filterMode <= (k == 2) ? 3'($urandom % 5) : 3'h5;
			acceptAllFrames <= (k == 3);
			acceptAllMulticast <= (k == 4);
			daValid <= 1'h1;
			destAddr <= da;
			@(posedge clk) daValid <= 1'h0;
			idx = hash_of(da);
			e = (k == 0) ? hw[idx[5:4]][idx[3:0]] : 1'h1;
			tick(1);
			chk(filterDone, 16'h1);
			chk(frameAccept, e);
		end
		$display("test address filter done");
		tally_and_finish();
	end
endmodule
